// >>> rtl/ook_decoder_pkg.sv
package ook_decoder_pkg;
	localparam logic [5:0] SYNC_LOW_NOMINAL = 6'h1F;
	localparam logic [5:0] TOL_NONE = 6'h00;
	localparam logic [5:0] TOL_SMALL = 6'h06;
	localparam logic [5:0] TOL_MID = 6'h0D;
	localparam logic [5:0] TOL_WIDE = 6'h14;
	localparam int FRAME_SYMS = 96;
	localparam int FIRST_BITS = 24;
	localparam int FIRST_ADDR_BITS = 20;
	localparam int LAST_BITS = 12;
	localparam logic [3:0] LAST_ADDR_MIN = 4'h8;
	localparam logic [3:0] CODE4_ZERO = 4'h8;
	localparam logic [3:0] CODE4_ONE = 4'hE;
	localparam logic [7:0] CODE8_ZERO = 8'h88;
	localparam logic [7:0] CODE8_ONE = 8'hEE;
	localparam logic [7:0] CODE8_FLOAT = 8'h8E;
	localparam logic [1:0] TRI_ZERO = 2'h0;
	localparam logic [1:0] TRI_ONE = 2'h1;
	localparam logic [1:0] TRI_FLOAT = 2'h2;
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_ADDR_FIRST = 8'h04;
	localparam logic [7:0] OFF_ADDR_LAST = 8'h08;
	localparam logic [7:0] OFF_PULSE_TIME = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam int CTRL_FORMAT_BIT = 0;
	localparam int CTRL_TOL_LSB = 1;
	localparam int CTRL_PULSE_BIT = 3;
	localparam int CTRL_LEN_LSB = 4;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0004;
	localparam logic [19:0] ADDR_FIRST_RESET = 20'h0_0000;
	localparam logic [21:0] ADDR_LAST_RESET = 22'h00_0000;
	localparam logic [3:0] PINS_RESET = 4'hF;
	localparam int CLK_MHZ = 200;
	localparam int PULSE_TIME_US = 1000;
	localparam int PULSE_RESET_CYCLES = PULSE_TIME_US * CLK_MHZ;
	typedef enum logic {HUNT, COLLECT} state_type;
endpackage

// >>> rtl/ook_packet_decoder.sv
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ook_packet_decoder #(
	parameter logic [31:0] PULSE_DEFAULT_CYCLES =
		32'(ook_decoder_pkg::PULSE_RESET_CYCLES)
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        sym_i,
	input  wire logic        sym_strobe_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             pin_out_first_o,
	output logic             pin_out_second_o,
	output logic             pin_out_third_o,
	output logic             pin_out_last_o,
	output logic             accept_o,
	output logic             reject_o
);

	// software-visible configuration
	logic        fmt_last;
	logic [1:0]  tol_sel;
	logic        pulse_en;
	logic [1:0]  len_sel;
	logic [19:0] link_address;
	logic [21:0] link_address_tri;
	logic [31:0] pulse_time;

	// symbol history and sync search
	logic [95:0] hist;
	logic [95:0] next_hist;
	logic [6:0]  fill;
	logic [5:0]  run_len;
	logic        seen_high;
	logic [95:0] snap;
	logic        snap_ok;
	logic [5:0]  tol;
	logic [5:0]  run_min;
	logic [5:0]  run_max;
	logic        sync_hit;

	// sync-first collection
	ook_decoder_pkg::state_type state;
	logic [6:0]  sym_cnt;
	logic        first_done;

	// decode results
	logic [23:0] f_ok;
	logic [23:0] f_val;
	logic        first_good;
	logic [11:0] l_match;
	logic [1:0]  l_tri [12];
	logic        last_good;
	logic        last_done;
	logic [3:0]  last_payload;
	logic [3:0]  addr_len;
	logic        next_accept;
	logic        next_reject;
	logic [3:0]  next_payload;

	// pins and pulse timer
	logic [3:0]  pins;
	logic        pulse_active;
	logic [31:0] pulse_left;
	logic [7:0]  n_accept;
	logic [7:0]  n_reject;

	// newest symbol enters at bit 0, oldest sits at bit 95
	assign next_hist = {hist[94:0], sym_i};

	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			hist <= '0;
			fill <= '0;
		end else if (sym_strobe_i) begin
			hist <= next_hist;
			if (fill != 7'(ook_decoder_pkg::FRAME_SYMS)) begin
				fill <= fill + 7'h01;
			end
		end
	end

	// tolerance window on the low run
	always_comb begin
		case (tol_sel)
			2'h0: tol = ook_decoder_pkg::TOL_NONE;
			2'h1: tol = ook_decoder_pkg::TOL_SMALL;
			2'h2: tol = ook_decoder_pkg::TOL_MID;
			default: tol = ook_decoder_pkg::TOL_WIDE;
		endcase
	end

	assign run_min = ook_decoder_pkg::SYNC_LOW_NOMINAL - tol;
	assign run_max = ook_decoder_pkg::SYNC_LOW_NOMINAL + tol;

	// a run is judged when the next high ends it, so the upper bound holds
	assign sync_hit = sym_strobe_i & sym_i & seen_high
		& (run_len >= run_min) & (run_len <= run_max);

	// low-run counter saturates so an endless quiet link cannot wrap
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			run_len <= '0;
			seen_high <= 1'b0;
		end else if (sym_strobe_i) begin
			if (sym_i) begin
				run_len <= '0;
				seen_high <= 1'b1;
			end else if (run_len != 6'h3F) begin
				run_len <= run_len + 6'h01;
			end
		end
	end

	// freeze the frame in front of each high; it may be a trailing sync
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			snap <= '0;
			snap_ok <= 1'b0;
		end else if (sym_strobe_i && sym_i) begin
			snap <= hist;
			snap_ok <= (fill == 7'(ook_decoder_pkg::FRAME_SYMS));
		end
	end

	// sync-first: the high that ends the sync is the first data symbol
	// a study header is never a valid sync, so study packets cannot move the pins
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state <= ook_decoder_pkg::HUNT;
			sym_cnt <= '0;
		end else begin
			case (state)
				ook_decoder_pkg::HUNT: begin
					if (sync_hit && !fmt_last) begin
						state <= ook_decoder_pkg::COLLECT;
						sym_cnt <= 7'h01;
					end
				end
				ook_decoder_pkg::COLLECT: begin
					if (first_done) begin
						state <= ook_decoder_pkg::HUNT;
					end else if (sym_strobe_i) begin
						sym_cnt <= sym_cnt + 7'h01;
					end
				end
				default: state <= ook_decoder_pkg::HUNT;
			endcase
		end
	end

	// the 96th symbol completes the frame; decode it as it arrives
	assign first_done = (state == ook_decoder_pkg::COLLECT) & sym_strobe_i
		& (sym_cnt == 7'(ook_decoder_pkg::FRAME_SYMS - 1));

	// sync-first bits: first symbol of a bit is the most significant
	// bit width is fixed at four symbols; a sender must use the same setting
	for (genvar k = 0; k < ook_decoder_pkg::FIRST_BITS; k++) begin : g_first
		logic [3:0] code;
		assign code = next_hist[95 - 4 * k -: 4];
		assign f_ok[k] = (code == ook_decoder_pkg::CODE4_ZERO)
			| (code == ook_decoder_pkg::CODE4_ONE);
		assign f_val[k] = (code == ook_decoder_pkg::CODE4_ONE);
	end

	// bit 0 of the address came first, payload follows it
	assign first_good = (&f_ok)
		& (f_val[ook_decoder_pkg::FIRST_ADDR_BITS - 1:0] == link_address);

	assign addr_len = ook_decoder_pkg::LAST_ADDR_MIN + {2'h0, len_sel};

	// sync-last bits: trinary address, binary data; no learning here
	for (genvar k = 0; k < ook_decoder_pkg::LAST_BITS; k++) begin : g_last
		logic [7:0] code;
		logic       is_addr;
		assign code = snap[95 - 8 * k -: 8];
		assign is_addr = (4'(k) < addr_len);
		always_comb begin
			case (code)
				ook_decoder_pkg::CODE8_ZERO: l_tri[k] = ook_decoder_pkg::TRI_ZERO;
				ook_decoder_pkg::CODE8_ONE: l_tri[k] = ook_decoder_pkg::TRI_ONE;
				ook_decoder_pkg::CODE8_FLOAT: l_tri[k] = ook_decoder_pkg::TRI_FLOAT;
				default: l_tri[k] = 2'h3;
			endcase
		end
		assign l_match[k] = is_addr
			? (l_tri[k] == link_address_tri[2 * k +: 2])
			: ((l_tri[k] == ook_decoder_pkg::TRI_ZERO)
				| (l_tri[k] == ook_decoder_pkg::TRI_ONE));
	end

	// data sent high bit first, so payload bit j is frame bit 11 - j
	for (genvar j = 0; j < 4; j++) begin : g_payload
		assign last_payload[j] = (4'(11 - j) >= addr_len)
			& (l_tri[11 - j] == ook_decoder_pkg::TRI_ONE);
	end

	assign last_done = sync_hit & fmt_last;
	assign last_good = snap_ok & (&l_match);

	// one verdict per completed frame
	always_comb begin
		next_accept = 1'b0;
		next_reject = 1'b0;
		next_payload = '0;
		if (first_done) begin
			next_accept = first_good;
			next_reject = !first_good;
			next_payload = f_val[23:20];
		end else if (last_done) begin
			next_accept = last_good;
			next_reject = !last_good;
			next_payload = last_payload;
		end
	end

	// verdict strobes come from flops so software sees clean pulses
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			accept_o <= 1'b0;
			reject_o <= 1'b0;
			n_accept <= '0;
			n_reject <= '0;
		end else begin
			accept_o <= next_accept;
			reject_o <= next_reject;
			if (next_accept) begin
				n_accept <= n_accept + 8'h01;
			end
			if (next_reject) begin
				n_reject <= n_reject + 8'h01;
			end
		end
	end

	// pins: a new packet beats an expiring pulse in the same cycle
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pins <= ook_decoder_pkg::PINS_RESET;
			pulse_active <= 1'b0;
			pulse_left <= '0;
		end else if (next_accept) begin
			pins <= ~next_payload;
			pulse_active <= pulse_en;
			pulse_left <= (pulse_time == 32'h0000_0000) ? 32'h0000_0001 : pulse_time;
		end else if (pulse_active) begin
			if (pulse_left == 32'h0000_0001) begin
				pins <= ook_decoder_pkg::PINS_RESET;
				pulse_active <= 1'b0;
			end else begin
				pulse_left <= pulse_left - 32'h0000_0001;
			end
		end
	end

	assign pin_out_first_o = pins[0];
	assign pin_out_second_o = pins[1];
	assign pin_out_third_o = pins[2];
	assign pin_out_last_o = pins[3];

	// configuration writes; changing format mid-frame may drop one packet
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			fmt_last <= ook_decoder_pkg::CTRL_RESET[ook_decoder_pkg::CTRL_FORMAT_BIT];
			tol_sel <= ook_decoder_pkg::CTRL_RESET[ook_decoder_pkg::CTRL_TOL_LSB +: 2];
			pulse_en <= ook_decoder_pkg::CTRL_RESET[ook_decoder_pkg::CTRL_PULSE_BIT];
			len_sel <= ook_decoder_pkg::CTRL_RESET[ook_decoder_pkg::CTRL_LEN_LSB +: 2];
			link_address <= ook_decoder_pkg::ADDR_FIRST_RESET;
			link_address_tri <= ook_decoder_pkg::ADDR_LAST_RESET;
			pulse_time <= PULSE_DEFAULT_CYCLES;
		end else if (wr_i) begin
			case (addr_i)
				ook_decoder_pkg::OFF_CTRL: begin
					fmt_last <= wdata_i[ook_decoder_pkg::CTRL_FORMAT_BIT];
					tol_sel <= wdata_i[ook_decoder_pkg::CTRL_TOL_LSB +: 2];
					pulse_en <= wdata_i[ook_decoder_pkg::CTRL_PULSE_BIT];
					len_sel <= wdata_i[ook_decoder_pkg::CTRL_LEN_LSB +: 2];
				end
				ook_decoder_pkg::OFF_ADDR_FIRST: link_address <= wdata_i[19:0];
				ook_decoder_pkg::OFF_ADDR_LAST: link_address_tri <= wdata_i[21:0];
				ook_decoder_pkg::OFF_PULSE_TIME: pulse_time <= wdata_i;
				default: ;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rdata_o <= '0;
		end else if (rd_i) begin
			case (addr_i)
				ook_decoder_pkg::OFF_CTRL:
					rdata_o <= {26'h0, len_sel, pulse_en, tol_sel, fmt_last};
				ook_decoder_pkg::OFF_ADDR_FIRST: rdata_o <= {12'h000, link_address};
				ook_decoder_pkg::OFF_ADDR_LAST: rdata_o <= {10'h000, link_address_tri};
				ook_decoder_pkg::OFF_PULSE_TIME: rdata_o <= pulse_time;
				ook_decoder_pkg::OFF_STATUS:
					rdata_o <= {8'h00, n_reject, n_accept, 2'h0, pulse_active,
						(state == ook_decoder_pkg::COLLECT), pins};
				default: rdata_o <= '0;
			endcase
		end else begin
			rdata_o <= '0;
		end
	end

endmodule
`default_nettype wire

// >>> verification/ook_pkt_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ook_pkt_chk #(
	parameter logic [31:0] PULSE_DEFAULT_CYCLES = 32'h0000_0014
) (
	input  wire logic        clk_i,
	input  wire logic        nrst_i,
	input  wire logic        sym_i,
	input  wire logic        sym_strobe_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	input  wire logic [31:0] rdata_o,
	input  wire logic        pin_out_first_o,
	input  wire logic        pin_out_second_o,
	input  wire logic        pin_out_third_o,
	input  wire logic        pin_out_last_o,
	input  wire logic        accept_o,
	input  wire logic        reject_o
);
	logic [3:0]  pins;
	logic        pen;
	logic [31:0] ptime;
	logic [31:0] age;
	assign pins = {pin_out_last_o, pin_out_third_o, pin_out_second_o, pin_out_first_o};
	// shadow of the pulse settings, seen only through bus writes
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			pen   <= 1'b0;
			ptime <= PULSE_DEFAULT_CYCLES;
		end else if (wr_i && addr_i == ook_decoder_pkg::OFF_CTRL) begin
			pen <= wdata_i[ook_decoder_pkg::CTRL_PULSE_BIT];
		end else if (wr_i && addr_i == ook_decoder_pkg::OFF_PULSE_TIME) begin
			ptime <= wdata_i;
		end
	end
	// cycles since last accept; saturates so it never wraps back into a window
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			age <= 32'hFFFF_FFFF;
		end else if (accept_o) begin
			age <= 32'h1;
		end else if (age != 32'hFFFF_FFFF) begin
			age <= age + 32'h1;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	sequence quiet;
		!accept_o && !reject_o;
	endsequence
	AST_RESET_PINS: assert property ($rose(nrst_i) |-> pins == 4'hF)
		else $error("pins not high after reset");
	AST_PULSE_END: assert property (pen && age == ptime && !accept_o |-> pins == 4'hF)
		else $error("pins not back high at pulse end");
	AST_PINS_HOLD: assert property (!accept_o && !(pen && age == ptime) |-> $stable(pins))
		else $error("pins moved without an accept");
	AST_ACCEPT_TIME: assert property (accept_o |-> $past(sym_strobe_i))
		else $error("accept not one cycle after a symbol");
	AST_REJECT_TIME: assert property (reject_o |-> $past(sym_strobe_i))
		else $error("reject not one cycle after a symbol");
	AST_ONE_SHOT: assert property ((accept_o || reject_o) |=> quiet)
		else $error("outcome pulse longer than one cycle");
	AST_NO_BOTH: assert property (!(accept_o && reject_o))
		else $error("accept and reject together");
	AST_RDATA_IDLE: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
		else $error("read data outside read slot");
endmodule
bind ook_packet_decoder ook_pkt_chk #(.PULSE_DEFAULT_CYCLES(PULSE_DEFAULT_CYCLES)) chk_i (
	.clk_i(clk_i), .nrst_i(nrst_i), .sym_i(sym_i), .sym_strobe_i(sym_strobe_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
	.pin_out_first_o(pin_out_first_o), .pin_out_second_o(pin_out_second_o),
	.pin_out_third_o(pin_out_third_o), .pin_out_last_o(pin_out_last_o),
	.accept_o(accept_o), .reject_o(reject_o));
`default_nettype wire

// >>> verification/ook_tx_model.sv
`timescale 1ns/1ps
`default_nettype none
module ook_tx_model (
	input  wire logic        clk_i,
	input  wire logic        go_i,
	input  wire logic        fmt_i,
	input  wire logic        slow_i,
	input  wire logic [3:0]  alen_i,
	input  wire logic [21:0] addr_i,
	input  wire logic [3:0]  data_i,
	input  wire logic [5:0]  low_i,
	output logic             sym_o,
	output logic             strobe_o,
	output logic             busy_o
);
	logic       q[$];
	logic [1:0] gap;
	initial begin
		sym_o = 1'b0;
		strobe_o = 1'b0;
		gap = 2'h0;
		busy_o = 1'b0;
	end
	task automatic put(input logic [7:0] c, input int n);
		for (int i = n - 1; i >= 0; i--) q.push_back(c[i]);
	endtask
	task automatic sync();
		put(8'h01, 1);
		for (int i = 0; i < low_i; i++) put(8'h00, 1);
	endtask
	function automatic logic [7:0] c8(input logic [1:0] t);
		return t == ook_decoder_pkg::TRI_ONE ? ook_decoder_pkg::CODE8_ONE :
			t == ook_decoder_pkg::TRI_FLOAT ? ook_decoder_pkg::CODE8_FLOAT :
			ook_decoder_pkg::CODE8_ZERO;
	endfunction
	// whole frame queued at go, then paced out; line toggles between symbols
	always @(posedge clk_i) begin
		if (go_i && !fmt_i) begin
			sync();
			for (int i = 0; i < 20; i++) put(addr_i[i] ? 8'h0E : 8'h08, 4);
			for (int i = 0; i < 4; i++) put(data_i[i] ? 8'h0E : 8'h08, 4);
		end else if (go_i) begin
			for (int i = 0; i < alen_i; i++) put(c8(addr_i[2*i+:2]), 8);
			for (int i = 11 - alen_i; i >= 0; i--) put(c8({1'b0, data_i[i]}), 8);
			sync();
			put(8'h01, 1);
		end
		if (gap == 2'h0 && q.size() != 0) begin
			strobe_o <= 1'b1;
			sym_o <= q.pop_front();
			gap <= {1'b0, slow_i} + 2'h1;
		end else begin
			strobe_o <= 1'b0;
			sym_o <= !sym_o;
			gap <= gap == 2'h0 ? gap : gap - 2'h1;
		end
		busy_o <= q.size() != 0;
	end
endmodule
`default_nettype wire

// >>> verification/ook_packet_decoder_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ook_packet_decoder_tb;
	logic        clk_i = 1'b0, nrst_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, go = 1'b0;
	logic        fmt = 1'b0, slow = 1'b0, sym_i, sym_strobe_i, accept_o, reject_o;
	logic        busy, acc, rej, p1, p2, p3, p4;
	logic [7:0]  addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0, rdata_o, v, r = 32'hDCC65044;
	logic [3:0]  alen = 4'h8, data = 4'h0, pins, exp = 4'hF;
	logic [21:0] ta = 22'h0;
	logic [5:0]  low = 6'h1F;
	logic [5:0]  tols [4] = '{6'h00, 6'h06, 6'h0D, 6'h14};
	int          mismatches = 0, compares = 0, k;
	assign pins = {p4, p3, p2, p1};
	always #2.5 clk_i = !clk_i;
	ook_packet_decoder uut (.clk_i(clk_i), .nrst_i(nrst_i), .sym_i(sym_i),
		.sym_strobe_i(sym_strobe_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .pin_out_first_o(p1), .pin_out_second_o(p2),
		.pin_out_third_o(p3), .pin_out_last_o(p4), .accept_o(accept_o), .reject_o(reject_o));
	ook_tx_model tx (.clk_i(clk_i), .go_i(go), .fmt_i(fmt), .slow_i(slow), .alen_i(alen),
		.addr_i(ta), .data_i(data), .low_i(low), .sym_o(sym_i), .strobe_o(sym_strobe_i),
		.busy_o(busy));
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input logic c, input string m);
		compares++;
		if (!c) begin
			mismatches++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 v = rdata_o;
	endtask
	// one frame; outcome flags gathered until the line has been quiet a while
	task automatic send();
		acc = 1'b0;
		rej = 1'b0;
		k = 0;
		@(posedge clk_i);
		go <= 1'b1;
		slow <= r[7];
		@(posedge clk_i);
		go <= 1'b0;
		for (int n = 0; n < 1200 && k < 4; n++) begin
			@(posedge clk_i);
			#1 acc |= accept_o;
			rej |= reject_o;
			k = busy ? 0 : k + 1;
		end
		if (k < 4) begin
			chk(1'b0, "frame never finished");
			stop_test();
		end
	endtask
	initial begin
		repeat (12) @(posedge clk_i);
		nrst_i <= 1'b1;
		@(posedge clk_i);
		#1 chk(pins === 4'hF, "pins after reset");
		rd(ook_decoder_pkg::OFF_CTRL);
		chk(v === ook_decoder_pkg::CTRL_RESET, "ctrl reset value");
		rd(8'h14);
		chk(v === 32'h0, "unmapped read");
		// each tolerance: both limits accepted, one beyond each limit ignored
		for (int t = 0; t < 16; t++) begin
			r = lfsr(r);
			wr(ook_decoder_pkg::OFF_CTRL, 32'(t[3:2]) << ook_decoder_pkg::CTRL_TOL_LSB);
			wr(ook_decoder_pkg::OFF_ADDR_FIRST, {12'h000, r[19:0]});
			ta = {2'h0, r[19:0]};
			data = r[23:20];
			low = t[0] ? 6'h1F + tols[t[3:2]] + 6'(t[1]) : 6'h1F - tols[t[3:2]] - 6'(t[1]);
			send();
			if (!t[1]) exp = ~data;
			chk(acc === !t[1], "sync tolerance");
			chk(pins === exp, "sync-first pins");
		end
		low = 6'h1F;
		ta = ta ^ 22'h1;
		send();
		chk(rej === 1'b1 && acc === 1'b0 && pins === exp, "address mismatch");
		// sync-last, every address length, each followed by a one-trit mismatch
		for (int len = 0; len < 8; len++) begin
			r = lfsr(r);
			for (int i = 0; i < 11; i++) ta[2*i+:2] = r[2*i+:2] % 2'h3;
			alen = 4'h8 + 4'(len[2:1]);
			low = r[28] ? 6'h12 : 6'h2C;
			data = r[27:24] & (4'hF >> len[2:1]);
			wr(ook_decoder_pkg::OFF_CTRL, 32'h5 | (32'(len[2:1]) << 4));
			wr(ook_decoder_pkg::OFF_ADDR_LAST, {10'h000, ta});
			if (len[0]) ta[1:0] = ta[1:0] == 2'h2 ? 2'h0 : ta[1:0] + 2'h1;
			fmt = 1'b1;
			send();
			if (!len[0]) exp = ~data;
			chk(acc === !len[0] && rej === len[0], "sync-last outcome");
			chk(pins === exp, "sync-last pins");
		end
		// pulse mode, data 1001 shows 0110 then all pins go back high
		wr(ook_decoder_pkg::OFF_PULSE_TIME, 32'h14);
		wr(ook_decoder_pkg::OFF_CTRL, 32'hC);
		wr(ook_decoder_pkg::OFF_ADDR_FIRST, 32'h5A5A5);
		fmt = 1'b0;
		ta = 22'h5A5A5;
		data = 4'h9;
		send();
		chk(pins === 4'h6, "pulse pins");
		repeat (20) @(posedge clk_i);
		#1 chk(pins === 4'hF, "pulse end");
		rd(ook_decoder_pkg::OFF_PULSE_TIME);
		chk(v === 32'h14, "pulse time readback");
		rd(ook_decoder_pkg::OFF_ADDR_FIRST);
		chk(v === 32'h5A5A5, "address readback");
		// 13 accepted and 5 refused frames so far, pins idle high
		rd(ook_decoder_pkg::OFF_STATUS);
		chk(v === 32'h0005_0D0F, "status counts and pins");
		stop_test();
	end
endmodule
`default_nettype wire
